// File: pkg/sapi_pkg.sv
// Purpose: Shared constants and carriers for the parallel-output converter control block
// Assumes: 40 MHz system clock
// Notes: Times kept in ns, cycle counts derived from the clock rate
package sapi_pkg;
  localparam int RES_BITS = 12;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_TIME_NS = 2700;
  localparam int ACQ_TIME_NS = 600;
  localparam int THROUGHPUT_SPS = 300000;
  // Longest time rounds down
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  // Least time rounds up
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_PERIOD_CYCLES = (1000000000 / THROUGHPUT_SPS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  // Sampling phase plus BIT_CYCLES cycles per bit plus latch cycle must fit CONV_CYCLES
  localparam int BIT_CYCLES = (CONV_CYCLES - 2) / RES_BITS;
  localparam logic [RES_BITS-1:0] RESULT_RESET = 12'h000;
  localparam logic [RES_BITS-1:0] MIDSCALE = 12'h800;

  typedef enum logic [3:0] {
    SAPI_IDLE = 4'b0001,
    SAPI_SAMPLE = 4'b0010,
    SAPI_CONVERT = 4'b0100,
    SAPI_LATCH = 4'b1000
  } sapi_state_e;

  typedef struct packed {
    logic chip_select_n;
    logic read_n;
    logic upper_byte_select;
  } sapi_host_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } sapi_data_s;
endpackage

// File: logic/sapi_sar_step.sv
// Purpose: One successive approximation step over the approximation register
// Assumes: Comparator high means input at or above trial level
// Notes: Pure combinational helper
`timescale 1ns/1ps
module sapi_sar_step
  import sapi_pkg::*;
#(
  parameter int WIDTH = RES_BITS
) (
  input wire logic [WIDTH-1:0] approximation_register,
  input wire logic [$clog2(WIDTH)-1:0] bit_index,
  input wire logic compare_high,
  output logic [WIDTH-1:0] trial,
  output logic [WIDTH-1:0] decided
);
  always_comb begin
    trial = approximation_register;
    trial[bit_index] = 1'b1;
    decided = approximation_register;
    decided[bit_index] = compare_high;
  end
endmodule

// File: logic/sapi_byte_mux.sv
// Purpose: Steers the held result onto the eight data pins
// Assumes: Result latches already hold a finished word
// Notes: Upper byte uses only the four shared lowest pins
`timescale 1ns/1ps
module sapi_byte_mux
  import sapi_pkg::*;
(
  input wire logic [RES_BITS-1:0] result_bits,
  input wire logic upper_byte_select,
  input wire logic drive,
  output sapi_data_s data
);
  always_comb begin
    data.oe = drive ? 8'hFF : 8'h00;
    if (upper_byte_select) begin
      data.out = {4'h0, result_bits[11:8]};
    end else begin
      data.out = result_bits[7:0];
    end
  end
endmodule

// File: logic/sapi_converter.sv
// Purpose: Start, conversion sequencing and readout of a 12-bit SAR converter
// Assumes: Host pins synchronous to clock; comparator decision valid each bit step
// Notes: Conversion timing restarts at every accepted start command
`timescale 1ns/1ps
module sapi_converter
  import sapi_pkg::*;
#(
  parameter bit BIPOLAR = 1'b0
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire sapi_host_s host,
  input wire logic compare_high,
  output logic [RES_BITS-1:0] dac_trial,
  output logic sample_hold,
  output logic busy_n,
  output logic [7:0] upper_data_pins,
  output logic [7:0] upper_data_oe,
  output logic [3:0] shared_low_data_pins,
  output logic [3:0] shared_low_data_oe
);
  localparam int IDX_W = $clog2(RES_BITS);
  localparam int STEP_W = $clog2(BIT_CYCLES + 1);

  sapi_state_e state;
  logic [RES_BITS-1:0] approximation_register;
  logic [RES_BITS-1:0] result_bits;
  logic [IDX_W-1:0] bit_index;
  logic [STEP_W-1:0] step_count;
  logic start_level;
  logic start_prev;
  logic start_edge;
  logic drive;
  logic [RES_BITS-1:0] trial;
  logic [RES_BITS-1:0] decided;
  sapi_data_s data;

  // Chip select gates starts and reads; upper select blocks starts
  assign start_level = !host.chip_select_n && !host.read_n && !host.upper_byte_select;
  // First cycle the condition is true is the sample instant
  assign start_edge = start_level && !start_prev;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      start_prev <= 1'b0;
    end else begin
      start_prev <= start_level;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= SAPI_IDLE;
    end else begin
      unique case (state)
        SAPI_IDLE: begin
          // Starts only accepted when idle; running conversion cannot restart
          if (start_edge) begin
            state <= SAPI_SAMPLE;
          end
        end
        SAPI_SAMPLE: begin
          state <= SAPI_CONVERT;
        end
        SAPI_CONVERT: begin
          if (bit_index == IDX_W'(0) && step_count == STEP_W'(BIT_CYCLES - 1)) begin
            state <= SAPI_LATCH;
          end
        end
        SAPI_LATCH: begin
          state <= SAPI_IDLE;
        end
      endcase
    end
  end

  // Bit timer restarts at every accepted start, never free-running
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      step_count <= '0;
      bit_index <= IDX_W'(RES_BITS - 1);
    end else if (state == SAPI_SAMPLE) begin
      step_count <= '0;
      bit_index <= IDX_W'(RES_BITS - 1);
    end else if (state == SAPI_CONVERT) begin
      if (step_count == STEP_W'(BIT_CYCLES - 1)) begin
        step_count <= '0;
        if (bit_index != IDX_W'(0)) begin
          bit_index <= bit_index - IDX_W'(1);
        end
      end else begin
        step_count <= step_count + STEP_W'(1);
      end
    end
  end

  sapi_sar_step #(
    .WIDTH(RES_BITS)
  ) u_step (
    .approximation_register(approximation_register),
    .bit_index(bit_index),
    .compare_high(compare_high),
    .trial(trial),
    .decided(decided)
  );

  // Cleared at start, one decision per bit at the end of its step
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      approximation_register <= RESULT_RESET;
    end else if (state == SAPI_SAMPLE) begin
      approximation_register <= RESULT_RESET;
    end else if (state == SAPI_CONVERT && step_count == STEP_W'(BIT_CYCLES - 1)) begin
      approximation_register <= decided;
    end
  end

  // Bipolar code flips MSB to reach two's complement around midscale
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      result_bits <= RESULT_RESET;
    end else if (state == SAPI_LATCH) begin
      if (BIPOLAR) begin
        result_bits <= approximation_register ^ MIDSCALE;
      end else begin
        result_bits <= approximation_register;
      end
    end
  end

  // Trial level registered in CONVERT, so the DAC sees it one cycle late, up to LATCH
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dac_trial <= RESULT_RESET;
    end else if (state == SAPI_CONVERT) begin
      dac_trial <= trial;
    end else begin
      dac_trial <= RESULT_RESET;
    end
  end

  // Hold opens again after latch so acquisition runs between conversions
  assign sample_hold = (state != SAPI_IDLE);
  assign busy_n = (state == SAPI_IDLE);

  // Outputs enabled whenever read and chip select are low, start included
  assign drive = !host.chip_select_n && !host.read_n;

  sapi_byte_mux u_mux (
    .result_bits(result_bits),
    .upper_byte_select(host.upper_byte_select),
    .drive(drive),
    .data(data)
  );

  // Twelve-bit word split over a byte-wide path
  always_comb begin
    upper_data_pins = {result_bits[11:8], data.out[7:4]};
    upper_data_oe = data.oe;
    shared_low_data_pins = data.out[3:0];
    shared_low_data_oe = data.oe[3:0];
  end
endmodule

// File: sim/sapi_cmp_model.sv
// Purpose: Comparator standing at the analog side of the converter
// Assumes: Held input given as an ideal code
// Notes: Answers at once; a slow comparator is not modelled
`timescale 1ns/1ps
module sapi_cmp_model
  import sapi_pkg::*;
(
  input wire logic [RES_BITS-1:0] dac_trial,
  input wire logic [RES_BITS-1:0] level,
  output logic compare_high
);
  // Keep the trial bit while the held level reaches it
  assign compare_high = (level >= dac_trial);
endmodule

// File: sim/sapi_converter_properties.sv
// Purpose: Port checks of the converter control block
// Assumes: Bit step of 8 cycles, so busy lasts 98 cycles
// Notes: Bound to every converter instance
`timescale 1ns/1ps
module sapi_checker
  import sapi_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire sapi_host_s host,
  input wire logic [RES_BITS-1:0] dac_trial,
  input wire logic sample_hold,
  input wire logic busy_n,
  input wire logic [7:0] upper_data_pins,
  input wire logic [7:0] upper_data_oe,
  input wire logic [3:0] shared_low_data_pins,
  input wire logic [3:0] shared_low_data_oe
);
  logic go;
  logic rd;
  logic [7:0] low_cnt;
  assign rd = !host.chip_select_n && !host.read_n;
  assign go = rd && !host.upper_byte_select;
  // Length of the current busy stretch
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      low_cnt <= 8'h00;
    else
      low_cnt <= busy_n ? 8'h00 : low_cnt + 8'h01;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_oe_upper: assert property (upper_data_oe == {8{rd}})
    else $error("upper enable wrong");
  a_oe_shared: assert property (shared_low_data_oe == {4{rd}})
    else $error("shared enable wrong");
  a_start_busy: assert property ($rose(go) && busy_n |=> !busy_n)
    else $error("start not taken");
  a_no_start: assert property (busy_n && !go |=> busy_n)
    else $error("busy without start");
  a_busy_len: assert property ($rose(busy_n) |-> low_cnt == 8'h62)
    else $error("busy length wrong");
  a_upper_byte: assert property (host.upper_byte_select |->
    shared_low_data_pins == upper_data_pins[7:4] && upper_data_pins[3:0] == 4'h0)
    else $error("upper byte steering wrong");
  a_sar_clear: assert property ($fell(busy_n) |-> ##3 dac_trial == 12'h800)
    else $error("first trial wrong");
  a_result_hold: assert property (busy_n && $past(busy_n) && $stable(host.upper_byte_select)
    |-> $stable(upper_data_pins) && $stable(shared_low_data_pins))
    else $error("result changed while idle");
  a_hold_busy: assert property (!busy_n |-> sample_hold)
    else $error("hold low during conversion");
  a_hold_idle: assert property (busy_n |-> !sample_hold)
    else $error("hold high while idle");
  c_start: cover property ($rose(go) && busy_n);
  c_upper: cover property (rd && host.upper_byte_select);
  c_done: cover property ($rose(busy_n));
endmodule
bind sapi_converter sapi_checker u_chk (.clock(clock), .arst_n(arst_n), .host(host),
  .dac_trial(dac_trial), .sample_hold(sample_hold), .busy_n(busy_n),
  .upper_data_pins(upper_data_pins), .upper_data_oe(upper_data_oe),
  .shared_low_data_pins(shared_low_data_pins), .shared_low_data_oe(shared_low_data_oe));

// File: sim/tb_top.sv
// Purpose: Self-checking bench of the converter control block
// Assumes: Host pins {chip_select_n, read_n, upper_byte_select}
// Notes: A low-byte read also starts the next conversion
`timescale 1ns/1ps
module tb_top
  import sapi_pkg::*;
;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  sapi_host_s host = 3'h6;
  logic [RES_BITS-1:0] level = 12'h000;
  logic compare_high;
  logic sample_hold;
  logic busy_n;
  logic [RES_BITS-1:0] dac_trial;
  logic [7:0] up;
  logic [7:0] up_oe;
  logic [3:0] lo;
  logic [3:0] lo_oe;
  logic cmp_b;
  logic [RES_BITS-1:0] trial_b;
  logic [7:0] up_b;
  logic [3:0] lo_b;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  sapi_converter DUT (.clock(clock), .arst_n(arst_n), .host(host),
    .compare_high(compare_high), .dac_trial(dac_trial), .sample_hold(sample_hold),
    .busy_n(busy_n), .upper_data_pins(up), .upper_data_oe(up_oe),
    .shared_low_data_pins(lo), .shared_low_data_oe(lo_oe));
  sapi_cmp_model cmp (.dac_trial(dac_trial), .level(level), .compare_high(compare_high));
  // Second instance sees the same host and input, in two's complement mode
  sapi_converter #(.BIPOLAR(1'b1)) DUT_B (.clock(clock), .arst_n(arst_n), .host(host),
    .compare_high(cmp_b), .dac_trial(trial_b), .sample_hold(), .busy_n(),
    .upper_data_pins(up_b), .upper_data_oe(), .shared_low_data_pins(lo_b),
    .shared_low_data_oe());
  sapi_cmp_model cmp_bi (.dac_trial(trial_b), .level(level), .compare_high(cmp_b));
  initial forever #12.5 clock = ~clock;
  task print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Pins move on the edge; outputs looked at once they settle
  task automatic put(logic [2:0] v);
    @(posedge clock);
    host <= sapi_host_s'(v);
    #1;
  endtask
  task automatic conv(logic [11:0] code, logic [11:0] prev, bit poke);
    int n;
    n = 0;
    level = code;
    put(3'h0);
    check("start word", {up, lo}, prev);
    check("start oe", {up_oe, lo_oe}, 12'hFFF);
    put(3'h6);
    check("busy", 12'(busy_n), 12'h000);
    check("hold", 12'(sample_hold), 12'h001);
    if (poke) begin
      put(3'h0);
      put(3'h6);
    end
    while (busy_n !== 1'b1 && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("busy cycles", n[11:0], poke ? 12'h060 : 12'h062);
    check("hold idle", 12'(sample_hold), 12'h000);
    // Settling time and rate limit kept by the host
    repeat (40) @(posedge clock);
    put(3'h1);
    check("upper word", {up, lo}, {code[11:8], 4'h0, code[11:8]});
    check("twos upper", {up_b, lo_b}, {code[11:8] ^ 4'h8, 4'h0, code[11:8] ^ 4'h8});
    put(3'h6);
    check("no start", 12'(busy_n), 12'h001);
    $display("test conv %h done", code);
  endtask
  task automatic refused();
    put(3'h4);
    check("oe idle", {up_oe, lo_oe}, 12'h000);
    put(3'h1);
    put(3'h6);
    check("no start", 12'(busy_n), 12'h001);
    $display("test refused done");
  endtask
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    conv(12'hA5C, 12'h000, 1'b0);
    refused();
    conv(12'h000, 12'hA5C, 1'b1);
    conv(12'hFFF, 12'h000, 1'b0);
    conv(12'h3C1, 12'hFFF, 1'b0);
    conv(12'h800, 12'h3C1, 1'b0);
    print_verdict();
  end
endmodule
